// [shared/fwr_defines.svh]
// constants of the fault waveform recorder
`ifndef FWR_DEFINES_SVH
`define FWR_DEFINES_SVH

// sample stream
`define FWR_SAMPLES_PER_CYCLE 64
`define FWR_SAMPLE_W 16
// record memory: 432 power cycles of 64 samples
`define FWR_MEM_CYCLES 432
`define FWR_ADDR_W 15
// history ring holds the longest pre-trigger part
`define FWR_HIST_DEPTH 512
`define FWR_HIST_AW 9
// record counts and record lengths in power cycles
`define FWR_NREC_6 6
`define FWR_NREC_12 12
`define FWR_NREC_24 24
`define FWR_NREC_36 36
`define FWR_CYC_6 72
`define FWR_CYC_12 36
`define FWR_CYC_24 18
`define FWR_CYC_36 12
// pre-trigger and split limits
`define FWR_PRE_MIN 1
`define FWR_PRE_MAX 8
`define FWR_SPLIT_MAX 100
// write path buffer depth
`define FWR_FIFO_DEPTH 8

`endif

// [shared/fwr_pkg.sv]
// types of the fault waveform recorder
package fwr_pkg;
   // record count choice
   typedef enum logic [1:0] {
      FWR_REC_6,
      FWR_REC_12,
      FWR_REC_24,
      FWR_REC_36
   } fwr_rec_sel_t;
   // capture sequencer
   typedef enum logic {
      FWR_ST_IDLE,
      FWR_ST_REC
   } fwr_state_t;
endpackage

// [rtl/fwr_fifo.sv]
// flip-flop fifo between the recorder and the record memory port
`timescale 1ns/10ps
module fwr_fifo #(
   parameter int WIDTH = 31,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic push, pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // handshakes and pointer updates
   always_comb begin
      push = in_valid_in && (count != FULL);
      pop = (count != '0) && out_ready_in;
      next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
      next_count = count + CW'(push) - CW'(pop);
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage, written only on a push
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   assign in_ready_out = (count != FULL);
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];
endmodule

// [rtl/fwr_recorder.sv]
// fault waveform recorder: history ring, record sequencer, memory write path
`timescale 1ns/10ps
`include "fwr_defines.svh"

// Contract
// R1 - four record counts, each fixing record length
// R2 - fixed memory split into equal slots
// R3 - full memory: new record overwrites oldest
// R4 - 1 to 8 pre-trigger cycles per record
// R5 - 64 samples stored per power cycle
// R6 - split never changes pre-trigger cycles
// R7 - long fault: keep split percent from end
// R8 - short fault: whole fault kept, split ignored
// R9 - circular history keeps recent pre-trigger samples
module fwr_recorder #(
   parameter int SAMPLE_W = `FWR_SAMPLE_W,
   parameter int FIFO_DEPTH = `FWR_FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // settings
   input wire fwr_pkg::fwr_rec_sel_t record_count_select_in,
   input wire logic [3:0] pretrigger_cycle_count_in,
   input wire logic [6:0] tail_split_percent_in,
   // sample stream from the acquisition front end
   input wire logic sample_valid_in,
   output logic sample_ready_out,
   input wire logic [SAMPLE_W-1:0] sample_data_in,
   input wire logic sample_fault_in,
   // record memory write port
   output logic mem_wr_valid_out,
   input wire logic mem_wr_ready_in,
   output logic [`FWR_ADDR_W-1:0] mem_wr_addr_out,
   output logic [SAMPLE_W-1:0] mem_wr_data_out,
   // record completion report
   output logic rec_done_out,
   output logic [5:0] rec_slot_out,
   output logic [`FWR_ADDR_W-1:0] rec_len_out,
   output logic rec_wrapped_out,
   output logic [`FWR_ADDR_W-1:0] rec_tail_ptr_out
);
   import fwr_pkg::*;
   localparam int AW = `FWR_ADDR_W;
   localparam int HW = `FWR_HIST_AW;
   localparam int FW = AW + SAMPLE_W;
   localparam logic [AW-1:0] SPC = AW'(`FWR_SAMPLES_PER_CYCLE);

   // record count and record length in samples for a choice
   function automatic logic [5:0] num_records(input fwr_rec_sel_t s);
      unique case (s)
         FWR_REC_6: num_records = 6'(`FWR_NREC_6);
         FWR_REC_12: num_records = 6'(`FWR_NREC_12);
         FWR_REC_24: num_records = 6'(`FWR_NREC_24);
         FWR_REC_36: num_records = 6'(`FWR_NREC_36);
      endcase
   endfunction

   function automatic logic [AW-1:0] rec_samples(input fwr_rec_sel_t s);
      logic [AW-1:0] cyc;
      cyc = '0;
      unique case (s)
         FWR_REC_6: cyc = AW'(`FWR_CYC_6);
         FWR_REC_12: cyc = AW'(`FWR_CYC_12);
         FWR_REC_24: cyc = AW'(`FWR_CYC_24);
         FWR_REC_36: cyc = AW'(`FWR_CYC_36);
      endcase
      rec_samples = AW'(cyc * SPC); // [R1] [R5]
   endfunction

   // sequencer state, slot, counters and settings held for the record in progress
   fwr_state_t state, next_state;
   logic [5:0] slot, next_slot, nrec, next_nrec;
   logic [AW-1:0] rec_len, next_rec_len, base, next_base, pre_len, next_pre_len;
   logic [AW-1:0] head_end, next_head_end, tail_len, next_tail_len;
   logic [AW-1:0] cnt, next_cnt, tptr, next_tptr;
   logic wrapped, next_wrapped;
   // history ring
   logic [SAMPLE_W:0] hist [`FWR_HIST_DEPTH];
   logic [HW-1:0] wp;
   // report registers
   logic done, next_done;
   logic [5:0] d_slot, next_d_slot;
   logic [AW-1:0] d_len, next_d_len, d_tptr, next_d_tptr;
   logic d_wrap, next_d_wrap;
   // datapath
   logic acc, dly_fault, push, finish;
   logic [SAMPLE_W:0] dly;
   logic [AW-1:0] push_addr, pre_in, fault_part;
   logic [6:0] split_in;
   logic [31:0] tail_calc;
   logic fifo_ready;

   // settings decode with clamping of out-of-range inputs
   always_comb begin
      if (pretrigger_cycle_count_in < 4'(`FWR_PRE_MIN)) begin
         pre_in = AW'(`FWR_PRE_MIN) * SPC;
      end else if (pretrigger_cycle_count_in > 4'(`FWR_PRE_MAX)) begin
         pre_in = AW'(`FWR_PRE_MAX) * SPC;
      end else begin
         pre_in = AW'(AW'(pretrigger_cycle_count_in) * SPC); // [R4] [R5]
      end
      split_in = (tail_split_percent_in > 7'(`FWR_SPLIT_MAX)) ?
                 7'(`FWR_SPLIT_MAX) : tail_split_percent_in;
      // split only divides the part after the pre-trigger samples
      fault_part = rec_samples(record_count_select_in) - pre_in; // [R6]
      tail_calc = (32'(fault_part) * 32'(split_in) + 32'd50) / 32'(`FWR_SPLIT_MAX); // [R7]
   end

   // delayed stream out of the history ring, pre-trigger length behind
   assign acc = sample_valid_in && fifo_ready;
   assign dly = hist[wp - HW'(pre_len)]; // [R9]
   assign dly_fault = dly[SAMPLE_W];

   // history ring: every accepted sample is kept, oldest overwritten
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wp <= '0;
      end else if (acc) begin
         wp <= wp + 1'b1; // [R9]
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (acc) begin
         hist[wp] <= {sample_fault_in, sample_data_in};
      end
   end

   // record sequencer
   always_comb begin
      next_state = state;
      next_slot = slot;
      next_nrec = nrec;
      next_rec_len = rec_len;
      next_base = base;
      next_pre_len = pre_len;
      next_head_end = head_end;
      next_tail_len = tail_len;
      next_cnt = cnt;
      next_tptr = tptr;
      next_wrapped = wrapped;
      next_done = 1'b0;
      next_d_slot = d_slot;
      next_d_len = d_len;
      next_d_tptr = d_tptr;
      next_d_wrap = d_wrap;
      push = 1'b0;
      push_addr = base;
      finish = 1'b0;
      unique case (state)
         FWR_ST_IDLE: begin
            // track settings while idle, slot base from slot index
            next_nrec = num_records(record_count_select_in);
            next_rec_len = rec_samples(record_count_select_in);
            next_base = AW'(AW'(slot) * rec_samples(record_count_select_in)); // [R2]
            next_pre_len = pre_in;
            next_tail_len = AW'(tail_calc);
            next_head_end = rec_samples(record_count_select_in) - AW'(tail_calc);
            if (slot >= num_records(record_count_select_in)) begin
               next_slot = '0;
            end
            if (acc && sample_fault_in && slot < nrec) begin
               next_state = FWR_ST_REC;
               push = 1'b1;
               push_addr = base;
               next_cnt = AW'(1);
               next_tptr = '0;
               next_wrapped = 1'b0;
            end
         end
         FWR_ST_REC: begin
            if (acc) begin
               if (cnt >= pre_len && !dly_fault) begin
                  finish = 1'b1; // [R8]
               end else if (cnt < head_end) begin
                  // pre-trigger part and head part, laid out in order
                  push = 1'b1; // [R4] [R8]
                  push_addr = base + cnt;
                  next_cnt = cnt + 1'b1;
               end else if (tail_len != '0) begin
                  // tail part runs circularly to keep the fault's end
                  push = 1'b1; // [R7]
                  push_addr = base + head_end + tptr;
                  next_tptr = (tptr + 1'b1 == tail_len) ? '0 : tptr + 1'b1;
                  if (cnt == rec_len) begin
                     next_wrapped = 1'b1;
                  end else begin
                     next_cnt = cnt + 1'b1;
                  end
               end else begin
                  next_wrapped = 1'b1;
               end
            end
            if (finish) begin
               next_state = FWR_ST_IDLE;
               next_done = 1'b1;
               next_d_slot = slot;
               next_d_len = cnt;
               next_d_wrap = wrapped;
               next_d_tptr = tptr;
               // round robin: after the last slot the oldest is reused
               next_slot = (slot + 1'b1 >= nrec) ? '0 : slot + 1'b1; // [R3]
               next_base = (slot + 1'b1 >= nrec) ? '0 : base + rec_len; // base ready for retrigger [R2]
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state <= FWR_ST_IDLE;
         slot <= '0;
         nrec <= 6'(`FWR_NREC_6);
         rec_len <= AW'(`FWR_CYC_6) * SPC;
         base <= '0;
         pre_len <= SPC;
         head_end <= '0;
         tail_len <= '0;
         cnt <= '0;
         tptr <= '0;
         wrapped <= 1'b0;
         done <= 1'b0;
         d_slot <= '0;
         d_len <= '0;
         d_tptr <= '0;
         d_wrap <= 1'b0;
      end else begin
         state <= next_state;
         slot <= next_slot;
         nrec <= next_nrec;
         rec_len <= next_rec_len;
         base <= next_base;
         pre_len <= next_pre_len;
         head_end <= next_head_end;
         tail_len <= next_tail_len;
         cnt <= next_cnt;
         tptr <= next_tptr;
         wrapped <= next_wrapped;
         done <= next_done;
         d_slot <= next_d_slot;
         d_len <= next_d_len;
         d_tptr <= next_d_tptr;
         d_wrap <= next_d_wrap;
      end
   end

   // write path buffer, its fullness stalls the sample stream
   fwr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .in_valid_in(push),
      .in_ready_out(fifo_ready),
      .in_data_in({push_addr, dly[SAMPLE_W-1:0]}),
      .out_valid_out(mem_wr_valid_out),
      .out_ready_in(mem_wr_ready_in),
      .out_data_out({mem_wr_addr_out, mem_wr_data_out})
   );

   assign sample_ready_out = fifo_ready;
   assign rec_done_out = done;
   assign rec_slot_out = d_slot;
   assign rec_len_out = d_len;
   assign rec_wrapped_out = d_wrap;
   assign rec_tail_ptr_out = d_tptr;

   // checks
   AST_SLOT_WRAP: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R3]
      (finish && slot + 1'b1 >= nrec) |=> (slot == '0 && rec_done_out))
      else $error("slot did not return to zero after last record");
   AST_ADDR_IN_SLOT: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R2]
      (push && state == FWR_ST_REC) |-> (push_addr >= base && push_addr < base + rec_len))
      else $error("write outside the current slot");
   AST_BASE_NEXT: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R2]
      finish |=> base == AW'(AW'(slot) * rec_len))
      else $error("slot base not ready after record close");
   AST_PRE_HELD: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R4]
      (state == FWR_ST_REC && acc && cnt < pre_len) |-> push ##1 state == FWR_ST_REC)
      else $error("pre-trigger part cut short");
   AST_LEN_TABLE: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R1]
      (state == FWR_ST_IDLE && $stable(record_count_select_in)) |=>
      (rec_len == rec_samples($past(record_count_select_in))
       && AW'(nrec) * rec_len == AW'(`FWR_MEM_CYCLES) * SPC))
      else $error("record length does not match record count");
   AST_SAMPLES_PER_CYC: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R5]
      state == FWR_ST_REC |-> (rec_len[5:0] == 6'h0 && pre_len[5:0] == 6'h0))
      else $error("record length not whole power cycles");
   AST_SPLIT_SHAPE: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R6]
      state == FWR_ST_REC |-> (head_end >= pre_len && head_end + tail_len == rec_len))
      else $error("split touches the pre-trigger part");
   AST_TAIL_ONLY_LONG: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R7]
      (push && state == FWR_ST_REC && cnt >= head_end) |-> push_addr >= base + head_end)
      else $error("tail write below tail region");
   AST_SHORT_WHOLE: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R8]
      (finish && !wrapped) |=> (rec_len_out == $past(cnt) && !rec_wrapped_out))
      else $error("short fault not kept whole");
   AST_HIST_ADV: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R9]
      acc |=> wp == $past(wp) + 1'b1)
      else $error("history ring did not advance");
endmodule

// [verif/fwr_source_model.sv]
// acquisition front end model: offers numbered samples with a fault flag
`timescale 1ns/10ps
`include "fwr_defines.svh"
module fwr_source_model (
   // clock
   input wire logic sys_clk_in,
   // sample stream
   output logic sample_valid_out,
   input wire logic sample_ready_in,
   output logic [`FWR_SAMPLE_W-1:0] sample_data_out,
   output logic sample_fault_out
);
   int idx = 0;
   // idle at time zero
   initial begin
      sample_valid_out = 1'b0;
      sample_data_out = 16'hFFFF;
      sample_fault_out = 1'b0;
   end
   // offer n samples, each held until taken, then gap idle cycles
   task automatic send(input int n, input logic f, input int gap);
      for (int i = 0; i < n; i++) begin
         sample_valid_out <= 1'b1;
         sample_data_out <= idx[`FWR_SAMPLE_W-1:0];
         sample_fault_out <= f;
         do @(negedge sys_clk_in); while (sample_ready_in !== 1'b1);
         @(posedge sys_clk_in);
         idx++;
         for (int g = 0; g < gap; g++) begin
            // released lines show the inverse, not the last value
            sample_valid_out <= 1'b0;
            sample_data_out <= ~sample_data_out;
            sample_fault_out <= ~sample_fault_out;
            @(posedge sys_clk_in);
         end
      end
   endtask
   // release the stream for one cycle
   task automatic quiet;
      sample_valid_out <= 1'b0;
      sample_data_out <= ~sample_data_out;
      sample_fault_out <= ~sample_fault_out;
      @(posedge sys_clk_in);
   endtask
endmodule

// [verif/test_fwr_recorder.sv]
// self-checking bench for the fault waveform recorder
`timescale 1ns/10ps
`include "fwr_defines.svh"
module test_fwr_recorder;
   import fwr_pkg::*;
   localparam int NREC[4] = '{`FWR_NREC_6, `FWR_NREC_12, `FWR_NREC_24, `FWR_NREC_36};
   localparam int CYC[4] = '{`FWR_CYC_6, `FWR_CYC_12, `FWR_CYC_24, `FWR_CYC_36};
   localparam int SPC = `FWR_SAMPLES_PER_CYCLE;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   fwr_rec_sel_t sel = FWR_REC_6;
   logic [3:0] pre_in = 4'h1;
   logic [6:0] split_in = 7'h00;
   logic s_valid, s_ready, s_fault, w_valid, done, d_wrap, wrapped;
   logic w_ready = 1'b1;
   logic stall = 1'b0;
   logic done_seen = 1'b0;
   logic first_seen = 1'b0;
   logic [15:0] s_data, w_data;
   logic [14:0] w_addr, r_len, r_ptr, d_len, d_ptr, first_addr;
   logic [5:0] r_slot, d_slot;
   logic [15:0] mem [0:`FWR_MEM_CYCLES*SPC-1];
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   int refusals = 0;

   fwr_recorder #(.SAMPLE_W(`FWR_SAMPLE_W), .FIFO_DEPTH(`FWR_FIFO_DEPTH)) dut (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .record_count_select_in(sel), .pretrigger_cycle_count_in(pre_in),
      .tail_split_percent_in(split_in),
      .sample_valid_in(s_valid), .sample_ready_out(s_ready),
      .sample_data_in(s_data), .sample_fault_in(s_fault),
      .mem_wr_valid_out(w_valid), .mem_wr_ready_in(w_ready),
      .mem_wr_addr_out(w_addr), .mem_wr_data_out(w_data),
      .rec_done_out(done), .rec_slot_out(r_slot), .rec_len_out(r_len),
      .rec_wrapped_out(wrapped), .rec_tail_ptr_out(r_ptr));
   fwr_source_model src (.sys_clk_in(sys_clk_in), .sample_valid_out(s_valid),
      .sample_ready_in(s_ready), .sample_data_out(s_data), .sample_fault_out(s_fault));

   // 200 MHz clock
   initial begin
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end

   // memory sink, completion capture, refusal count, hang guard
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      w_ready <= !stall || (cyc % 4 == 0);
      if (s_valid && !s_ready) refusals <= refusals + 1;
      if (w_valid && w_ready) begin
         mem[w_addr] <= w_data;
         if (!first_seen) first_addr <= w_addr;
         first_seen <= 1'b1;
      end
      if (done) begin
         done_seen <= 1'b1;
         d_slot <= r_slot;
         d_len <= r_len;
         d_wrap <= wrapped;
         d_ptr <= r_ptr;
      end
      if (cyc == 60000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic reset_dut;
      rst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask

   // one record: prime history, fault of f samples, close; then judge slot and contents
   task automatic run_rec(input int s, input int p_in, input int p, input int sp,
                          input int f, input int sl, input int gap);
      int len;
      int pre;
      int tail;
      int hend;
      int ptr;
      int t;
      int e;
      int n;
      bit lng;
      sel <= fwr_rec_sel_t'(s);
      pre_in <= 4'(p_in);
      split_in <= 7'(sp);
      done_seen <= 1'b0;
      first_seen <= 1'b0;
      pre = p * SPC;
      src.send(pre + 8, 1'b0, 0);
      t = src.idx;
      src.send(f, 1'b1, gap);
      src.send(pre + 8, 1'b0, gap);
      src.quiet();
      n = 0;
      while (!(done_seen && w_valid === 1'b0) && n < 5000) begin
         @(posedge sys_clk_in);
         n++;
      end
      len = CYC[s] * SPC;
      tail = ((len - pre) * sp + 50) / 100;
      hend = len - tail;
      lng = f > len - pre;
      ptr = (lng && tail > 0) ? (f - (hend - pre)) % tail : 0;
      chk("done", 1, 32'(done_seen));
      chk("slot", sl, 32'(d_slot));
      chk("first address", sl * len, 32'(first_addr));
      chk("length", lng ? len : pre + f, 32'(d_len));
      chk("wrapped", 32'(lng), 32'(d_wrap));
      if (lng && tail > 0) chk("tail pointer", ptr, 32'(d_ptr));
      for (int k = 0; k < (lng ? len : pre + f); k++) begin
         e = (lng && k >= hend) ? t + f - tail + (k - hend - ptr + tail) % tail : t - pre + k;
         chk("sample", 32'(e[15:0]), 32'(mem[sl * len + k]));
      end
   endtask

   // short faults with slow source; pre-trigger count and its limits
   task automatic test_short_fault;
      run_rec(1, 2, 2, 50, 100, 0, 1);
      run_rec(1, 0, 1, 50, 100, 1, 1);
      run_rec(1, 12, 8, 50, 100, 2, 1);
      $display("short fault test done");
   endtask

   // long faults at split 0, 30 and 100 with a stalling memory
   task automatic test_long_split;
      int sp[3] = '{0, 30, 100};
      reset_dut();
      stall <= 1'b1;
      for (int i = 0; i < 3; i++) run_rec(3, 1, 1, sp[i], 1000, i, 0);
      stall <= 1'b0;
      chk("input refused while full", 1, 32'(refusals > 0));
      $display("long fault split test done");
   endtask

   // every record count, one record past full to overwrite the oldest slot
   task automatic test_round_robin;
      for (int s = 0; s < 4; s++) begin
         reset_dut();
         for (int r = 0; r <= NREC[s]; r++) run_rec(s, 1, 1, 0, 4, r % NREC[s], 0);
      end
      $display("round robin test done");
   endtask

   // main sequence
   initial begin
      repeat (6) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      test_short_fault();
      test_long_split();
      test_round_robin();
      wrap_up();
   end
endmodule
